// File: design/dcmqr_top.sv
// Purpose: Maps DMA and triggered-write channels to parameter sets and routes
//          DMA channel events through six queues to their transfer controllers.
// Assumes: Channel events and parameter set writes come from logic on i_ref_clk.
// Notes: Reads take one wait state, writes none; the response is always OKAY.
`timescale 1ns/10ps
`default_nettype none

// Contract
// (R1) Each DMA channel map holds a 9-bit set index in bits 13:5.
// (R2) Triggered-write set indices 0..255 valid; 256..511 reserved, never match.
// (R3) Triggered-write map holds a 3-bit trigger word selector in bits 4:2.
// (R4) A write to the selected word of the mapped set raises that channel's event.
// (R5) Triggered-write maps reset to parameter set zero.
// (R6) Software should remap triggered-write channels away from set zero first.
// (R7) Every DMA channel may send its event to any queue by its queue number.
// (R8) Queue codes 0..5 select queues 0..5; codes 6 and 7 reserved.
// (R9) All DMA channel queue numbers reset to zero.
// (R10) Software must not program a queue number beyond implemented queues.
// (R11) Requests from queue k go to transfer controller k.
// (R12) Queue register n field k: channel 8n+k in bits 4k+2:4k.
// (R13) Exactly six event queues, each with its own transfer controller.
// (R14) 256 parameter sets exist; valid indices are 0..255.
// (R15) Reserved bits read zero and ignore writes.
module dcmqr_top
    import dcmqr_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata,
    input wire logic [NUM_DMA_CH-1:0] i_dma_evt,
    input wire dcmqr_pwr_s i_pset_wr,
    output logic [NUM_TRIGGERED_WRITE_CHANNEL_CH-1:0] o_triggered_write_channel_evt,
    output logic [NUM_QUEUES-1:0] o_tr_valid,
    output dcmqr_tr_s [NUM_QUEUES-1:0] o_tr,
    input wire logic [NUM_QUEUES-1:0] i_tr_ready
);
    // Stored configuration
    // Kept as plain arrays: small enough for flops, and every field
    // must be readable in the same cycle by the bus and the routers
    logic [PSET_W-1:0] dmap [NUM_DMA_CH];
    logic [PSET_W-1:0] qmap_set [NUM_TRIGGERED_WRITE_CHANNEL_CH];
    logic [TRIG_W-1:0] qmap_word [NUM_TRIGGERED_WRITE_CHANNEL_CH];
    logic [QNUM_W-1:0] qnum [NUM_DMA_CH];

    // Bus slave state
    dcmqr_state_e state;
    logic [ADDR_W-1:0] dp_addr;
    logic accept;
    logic hit_dmap;
    logic hit_qmap;
    logic hit_qnum;
    logic [CH_W-1:0] dmap_idx;
    logic [QCH_W-1:0] reg_idx;
    logic [31:0] rd_mux;

    // Channel event bookkeeping
    // One pending bit per channel; repeats merge while a bit is set,
    // which trades event counting for a flat, queue-free structure
    logic [NUM_DMA_CH-1:0] pend;
    logic [NUM_DMA_CH-1:0] evt_ok;
    logic [NUM_DMA_CH-1:0] clr_all;
    logic [NUM_DMA_CH-1:0] clr_q [NUM_QUEUES];
    logic [NUM_QUEUES-1:0] found;
    logic [NUM_QUEUES-1:0] load;
    logic [CH_W-1:0] pick [NUM_QUEUES];
    logic [NUM_DMA_CH-1:0] stale;
    logic [NUM_TRIGGERED_WRITE_CHANNEL_CH-1:0] qset_ok;

    // Address phase is taken only when the bus is ready
    // Transfer size is not checked; every access counts as a whole word
    // Upper address bits are ignored, so the window aliases every 4 KB
    assign accept = i_hsel && i_hready && (i_htrans == HTRANS_NONSEQ);

    // Decode of the captured data phase address
    // Register groups do not overlap, so the order of the chain is free
    // Unmapped addresses hit nothing: writes vanish, reads return zero
    always_comb begin
        hit_dmap = 1'b0;
        hit_qmap = 1'b0;
        hit_qnum = 1'b0;
        if (dp_addr >= DMAP_BASE && dp_addr < DMAP_BASE + ADDR_W'(DMAP_SPAN)) begin
            hit_dmap = 1'b1;
        end else if (dp_addr >= QMAP_BASE && dp_addr < QMAP_BASE + ADDR_W'(QMAP_SPAN)) begin
            hit_qmap = 1'b1;
        end else if (dp_addr >= QNUM_BASE && dp_addr < QNUM_BASE + ADDR_W'(QNUM_SPAN)) begin
            hit_qnum = 1'b1;
        end
    end

    // Word index within each register group
    assign dmap_idx = dp_addr[CH_W+1:2];
    assign reg_idx = dp_addr[QCH_W+1:2];

    // Data phase address, captured with each accepted address phase
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            dp_addr <= '0;
        end else if (accept) begin
            dp_addr <= i_haddr[ADDR_W-1:0];
        end
    end

    // Bus state machine: writes commit in the data phase, reads wait one cycle
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE, ST_WRITE: begin
                    if (accept) begin
                        state <= i_hwrite ? ST_WRITE : ST_READ;
                    end else begin
                        state <= ST_IDLE;
                    end
                end
                ST_READ: begin
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Ready drops for the single read wait state, so a read always sees
    // a write that completed in the previous data phase
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_hreadyout <= 1'b1;
        end else if (state == ST_READ) begin
            o_hreadyout <= 1'b1;
        end else begin
            o_hreadyout <= !(accept && !i_hwrite);
        end
    end

    // Only OKAY is ever answered; unmapped addresses read zero
    // Kept as a flop so that every output leaves a register
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_hresp <= HRESP_OKAY;
        end else begin
            o_hresp <= HRESP_OKAY;
        end
    end

    // Read data assembled from the stored fields, reserved bits zero
    // Stored reserved set indices read back as written, so software
    // can see what it programmed even though they never match
    always_comb begin
        rd_mux = '0;
        if (hit_dmap) begin
            rd_mux[PSET_LSB +: PSET_W] = dmap[dmap_idx]; // R1 R15
        end else if (hit_qmap) begin
            rd_mux[PSET_LSB +: PSET_W] = qmap_set[reg_idx]; // R15
            rd_mux[TRIG_LSB +: TRIG_W] = qmap_word[reg_idx]; // R3
        end else if (hit_qnum) begin
            for (int k = 0; k < QFIELDS_PER_REG; k++) begin
                rd_mux[k*QFIELD_STRIDE +: QNUM_W] = qnum[{reg_idx, QCH_W'(k)}]; // R12 R15
            end
        end
    end

    // Read data register loaded at the end of the wait state
    // Holds its value until the next read, so a slow master is safe
    // Cost of the register is the wait state on every read
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_hrdata <= '0;
        end else if (state == ST_READ) begin
            o_hrdata <= rd_mux;
        end
    end

    // DMA channel parameter set maps
    // All nine index bits are stored; nothing checks them against the set count
    // Reserved bits of the written word are simply not captured
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            for (int c = 0; c < NUM_DMA_CH; c++) begin
                dmap[c] <= PSET_RST;
            end
        end else if (state == ST_WRITE && hit_dmap) begin
            dmap[dmap_idx] <= i_hwdata[PSET_LSB +: PSET_W]; // R1 R15
        end
    end

    // Triggered-write set indices; reserved values are kept but never match
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            for (int q = 0; q < NUM_TRIGGERED_WRITE_CHANNEL_CH; q++) begin
                qmap_set[q] <= PSET_RST; // R5
            end
        end else if (state == ST_WRITE && hit_qmap) begin
            qmap_set[reg_idx] <= i_hwdata[PSET_LSB +: PSET_W]; // R2
        end
    end

    // Triggered-write trigger word selectors
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            for (int q = 0; q < NUM_TRIGGERED_WRITE_CHANNEL_CH; q++) begin
                qmap_word[q] <= TRIG_RST;
            end
        end else if (state == ST_WRITE && hit_qmap) begin
            qmap_word[reg_idx] <= i_hwdata[TRIG_LSB +: TRIG_W]; // R3 R15
        end
    end

    // Queue numbers, eight channels per register
    // Every fourth bit is reserved and dropped on the way in
    // A code change takes effect on the next arbitration cycle
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            for (int c = 0; c < NUM_DMA_CH; c++) begin
                qnum[c] <= QNUM_RST; // R9
            end
        end else if (state == ST_WRITE && hit_qnum) begin
            for (int k = 0; k < QFIELDS_PER_REG; k++) begin
                qnum[{reg_idx, QCH_W'(k)}] <= i_hwdata[k*QFIELD_STRIDE +: QNUM_W]; // R12
            end
        end
    end

    // Only indices below the set count name real memory; the rest never match
    generate
        for (genvar q = 0; q < NUM_TRIGGERED_WRITE_CHANNEL_CH; q++) begin : g_qset
            assign qset_ok[q] = (qmap_set[q] < PSET_W'(NUM_PSETS)); // R2 R14
        end
    endgenerate

    // Trigger word match per triggered-write channel, one-cycle event pulse
    generate
        for (genvar q = 0; q < NUM_TRIGGERED_WRITE_CHANNEL_CH; q++) begin : g_triggered_write_channel
            always_ff @(posedge i_ref_clk or posedge i_rst) begin
                if (i_rst) begin
                    o_triggered_write_channel_evt[q] <= 1'b0;
                end else begin
                    o_triggered_write_channel_evt[q] <= i_pset_wr.valid
                        && qset_ok[q] // R2 R14
                        && (qmap_set[q][PSET_ADDR_W-1:0] == i_pset_wr.pset) // R4
                        && (qmap_word[q] == i_pset_wr.word); // R4
                end
            end
        end
    endgenerate

    // Events aimed at a reserved queue code are dropped rather than stranded
    // No queue exists behind codes 6 and 7, so nothing could ever
    // take such an event and its pending bit would block forever
    generate
        for (genvar c = 0; c < NUM_DMA_CH; c++) begin : g_evt
            assign evt_ok[c] = i_dma_evt[c] && (qnum[c] < QNUM_W'(NUM_QUEUES)); // R8 R13
        end
    endgenerate

    // A pending event whose code turned reserved is dropped, not stranded
    generate
        for (genvar c = 0; c < NUM_DMA_CH; c++) begin : g_stale
            assign stale[c] = (qnum[c] >= QNUM_W'(NUM_QUEUES)); // R8
        end
    endgenerate

    // Merge of the per-queue grant masks
    always_comb begin
        clr_all = '0;
        for (int k = 0; k < NUM_QUEUES; k++) begin
            clr_all = clr_all | clr_q[k];
        end
    end

    // Pending events; a new event in the grant cycle survives the clear
    // Set wins over clear, so an event is never lost to a grant
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            pend <= '0;
        end else begin
            pend <= (pend & ~clr_all & ~stale) | evt_ok; // R7
        end
    end

    // One arbiter and request register per queue, lowest channel first
    // Fixed priority is simple but lets a busy low channel starve
    // higher ones on the same queue; queue choice is the remedy
    // The pick is ripple logic over all channels, the slowest path here
    generate
        for (genvar k = 0; k < NUM_QUEUES; k++) begin : g_queue
            // Lowest pending channel that names this queue
            always_comb begin
                found[k] = 1'b0;
                pick[k] = '0;
                for (int c = 0; c < NUM_DMA_CH; c++) begin
                    if (!found[k] && pend[c] && qnum[c] == QNUM_W'(k)) begin // R7 R8
                        found[k] = 1'b1;
                        pick[k] = CH_W'(c);
                    end
                end
            end

            // Reload when the slot is empty or being taken this cycle
            // Back to back requests need no idle cycle while ready stays high
            // The grant clears exactly the channel that was loaded
            assign load[k] = found[k] && (!o_tr_valid[k] || i_tr_ready[k]);
            assign clr_q[k] = load[k] ? (NUM_DMA_CH'(1) << pick[k]) : '0;

            // Request held until transfer controller k takes it
            always_ff @(posedge i_ref_clk or posedge i_rst) begin
                if (i_rst) begin
                    o_tr_valid[k] <= 1'b0;
                end else if (!o_tr_valid[k] || i_tr_ready[k]) begin
                    o_tr_valid[k] <= found[k]; // R11
                end
            end

            // Payload loads with the valid, so it cannot move while stalled
            always_ff @(posedge i_ref_clk or posedge i_rst) begin
                if (i_rst) begin
                    o_tr[k] <= '0;
                end else if (!o_tr_valid[k] || i_tr_ready[k]) begin
                    o_tr[k].chan <= pick[k];
                    o_tr[k].pset <= dmap[pick[k]]; // R1 R11
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// File: design/dcmqr_pkg.sv
// Purpose: Shared constants and carriers for the channel map and queue router.
// Assumes: One 20 MHz clock, AHB-Lite register access with 32-bit words.
// Notes: Register offsets are byte addresses within the block's 4 KB window.
package dcmqr_pkg;
    // Sizes of the channel controller
    localparam int NUM_DMA_CH = 64;
    localparam int NUM_TRIGGERED_WRITE_CHANNEL_CH = 8;
    localparam int NUM_QUEUES = 6;
    localparam int NUM_PSETS = 256;
    localparam int PSET_W = 9;
    localparam int PSET_ADDR_W = 8;
    localparam int TRIG_W = 3;
    localparam int QNUM_W = 3;
    localparam int CH_W = 6;
    localparam int QCH_W = 3;
    localparam int QFIELDS_PER_REG = 8;
    localparam int QFIELD_STRIDE = 4;

    // Field positions inside the map registers
    localparam int PSET_LSB = 5;
    localparam int TRIG_LSB = 2;

    // Register window, byte addresses
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] DMAP_BASE = 12'h000;
    localparam logic [ADDR_W-1:0] QMAP_BASE = 12'h200;
    localparam logic [ADDR_W-1:0] QNUM_BASE = 12'h240;
    localparam int DMAP_SPAN = 256;
    localparam int QMAP_SPAN = 32;
    localparam int QNUM_SPAN = 32;

    // Reset values of the stored fields
    localparam logic [PSET_W-1:0] PSET_RST = 9'h000;
    localparam logic [TRIG_W-1:0] TRIG_RST = 3'h0;
    localparam logic [QNUM_W-1:0] QNUM_RST = 3'h0;

    // AHB-Lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'h0;

    // Bus slave states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WRITE = 3'b010,
        ST_READ = 3'b100
    } dcmqr_state_e;

    // Transfer request handed to transfer controller k
    typedef struct packed {
        logic [CH_W-1:0] chan;
        logic [PSET_W-1:0] pset;
    } dcmqr_tr_s;

    // Write seen by the parameter set memory
    typedef struct packed {
        logic valid;
        logic [PSET_ADDR_W-1:0] pset;
        logic [TRIG_W-1:0] word;
    } dcmqr_pwr_s;
endpackage

// File: test/dcmqr_chk.sv
// Purpose: Port-level checks of the register bus and the request links.
// Assumes: One clock, asynchronous high reset, hready tied to hreadyout.
// Notes: Map contents are not modelled here; the bench checks them.
`timescale 1ns/10ps
`default_nettype none
module dcmqr_chk
    import dcmqr_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_hsel,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic i_hready,
    input wire logic o_hreadyout,
    input wire logic o_hresp,
    input wire dcmqr_pwr_s i_pset_wr,
    input wire logic [NUM_TRIGGERED_WRITE_CHANNEL_CH-1:0] o_triggered_write_channel_evt,
    input wire logic [NUM_QUEUES-1:0] o_tr_valid,
    input wire dcmqr_tr_s [NUM_QUEUES-1:0] o_tr,
    input wire logic [NUM_QUEUES-1:0] i_tr_ready
);
    default clocking dc @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    logic take;
    logic [NUM_QUEUES-1:0] stall_q;
    dcmqr_tr_s [NUM_QUEUES-1:0] tr_q;
    // Address phase accepted by the slave
    assign take = i_hsel && i_hready && i_htrans == HTRANS_NONSEQ;
    // Requests left waiting at the last edge, and what they carried
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            stall_q <= '0;
            tr_q <= '0;
        end else begin
            stall_q <= o_tr_valid & ~i_tr_ready;
            tr_q <= o_tr;
        end
    end
    AST_RD_WAIT: assert property (take && !i_hwrite |=> !o_hreadyout ##1 o_hreadyout)
        else $error("read wait state wrong");
    AST_WR_NOWAIT: assert property (take && i_hwrite |=> o_hreadyout)
        else $error("write stalled");
    AST_IDLE_RDY: assert property (!take && o_hreadyout |=> o_hreadyout)
        else $error("idle bus stalled");
    AST_HRESP: assert property (o_hresp == HRESP_OKAY)
        else $error("response not okay");
    AST_QEVT_IDLE: assert property (!i_pset_wr.valid |=> o_triggered_write_channel_evt == '0)
        else $error("trigger event without set write");
    AST_TR_HOLD: assert property ((stall_q & ~o_tr_valid) == '0)
        else $error("request dropped before accept");
    AST_RST_VAL: assert property ($fell(i_rst) |-> o_tr_valid == '0 && o_hreadyout)
        else $error("outputs wrong after reset");
    // Stalled request content must not move
    for (genvar k = 0; k < NUM_QUEUES; k++) begin : g_q
        AST_TR_STABLE: assert property (stall_q[k] |-> o_tr[k] == tr_q[k])
            else $error("request changed while stalled");
    end
    COV_RD: cover property (take && !i_hwrite);
    COV_QEVT: cover property (o_triggered_write_channel_evt != '0);
    COV_STALL: cover property (stall_q != '0);
endmodule
`default_nettype wire

// File: test/dcmqr_tc_model.sv
// Purpose: Six transfer controllers that either stall or accept at once.
// Assumes: Requests stay valid until accepted.
// Notes: Stalling is the default, since real controllers fill up.
`timescale 1ns/10ps
`default_nettype none
module dcmqr_tc_model
    import dcmqr_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_go,
    input wire logic [NUM_QUEUES-1:0] i_tr_valid,
    output logic [NUM_QUEUES-1:0] o_tr_ready,
    output logic [7:0] o_taken
);
    // Ready per controller, one per queue
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_tr_ready <= '0;
        end else begin
            o_tr_ready <= {NUM_QUEUES{i_go}};
        end
    end
    // Count of requests accepted over all controllers
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_taken <= '0;
        end else begin
            o_taken <= o_taken + 8'($countones(i_tr_valid & o_tr_ready));
        end
    end
endmodule
`default_nettype wire

// File: test/dcmqr_tb_top.sv
// Purpose: Register, routing and trigger-word tests for the router.
// Assumes: AHB-Lite master with one slave, hready fed from hreadyout.
// Notes: Queue codes stay within the six implemented queues.
`timescale 1ns/10ps
`default_nettype none
module dcmqr_tb_top;
    import dcmqr_pkg::*;
    logic clk, rst, hwrite, hrdy, hresp, go;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata;
    logic [NUM_DMA_CH-1:0] evt;
    dcmqr_pwr_s pw;
    logic [NUM_TRIGGERED_WRITE_CHANNEL_CH-1:0] qevt;
    logic [NUM_QUEUES-1:0] tv, trdy;
    dcmqr_tr_s [NUM_QUEUES-1:0] tr;
    logic [7:0] taken;
    int failures, cmp_count, cyc;
    dcmqr_top dcmqr_top_i (.i_ref_clk(clk), .i_rst(rst), .i_hsel(1'b1), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hrdy), .o_hreadyout(hrdy), .o_hresp(hresp), .o_hrdata(hrdata),
        .i_dma_evt(evt), .i_pset_wr(pw), .o_triggered_write_channel_evt(qevt), .o_tr_valid(tv), .o_tr(tr),
        .i_tr_ready(trdy));
    dcmqr_tc_model dcmqr_tc_model_i (.i_ref_clk(clk), .i_rst(rst), .i_go(go),
        .i_tr_valid(tv), .o_tr_ready(trdy), .o_taken(taken));
    task automatic results();
        if (failures == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Waits for an edge at which hready is high
    task automatic hwait();
        logic ok;
        do begin
            @(negedge clk);
            ok = hrdy;
            @(posedge clk);
        end while (ok !== 1'b1);
    endtask
    task automatic aph(input logic [11:0] a, input logic w);
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {20'h00000, a};
        hwait();
        htrans <= 2'h0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        aph(a, 1'b1);
        hwdata <= d;
        hwait();
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        aph(a, 1'b0);
        hwait();
        chk(hrdata, e);
    endtask
    // One parameter set write, then the trigger events one cycle on
    task automatic qhit(input dcmqr_pwr_s p, input logic [7:0] e);
        @(posedge clk);
        pw <= p;
        @(posedge clk);
        pw <= '0;
        #1;
        chk({24'h0, qevt}, {24'h0, e});
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Hang guard, well above the run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            failures++;
            $display("[ERR] %0t timeout", $time);
            results();
        end
    end
    initial begin
        {rst, go, hwrite, htrans, haddr, hwdata, evt, pw} = '0;
        rst = 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd(DMAP_BASE, 32'h0);
        rd(QMAP_BASE + 12'h1C, 32'h0);
        rd(QNUM_BASE + 12'h1C, 32'h0);
        wr(DMAP_BASE + 12'h14, 32'hFFFFFFFF);
        rd(DMAP_BASE + 12'h14, 32'h00003FE0);
        wr(QMAP_BASE + 12'h04, 32'hFFFFFFFF);
        rd(QMAP_BASE + 12'h04, 32'h00003FFC);
        wr(QNUM_BASE + 12'h1C, 32'hDDDDDDDD);
        rd(QNUM_BASE + 12'h1C, 32'h55555555);
        rd(12'h300, 32'h0);
        // Channels 0..5 get queue k; 6 and 7 wait on queue 0 behind channel 0
        wr(QNUM_BASE, 32'h00543210);
        wr(QMAP_BASE + 12'h0C, 32'h00000254);
        evt <= 64'hFF;
        @(posedge clk);
        evt <= '0;
        repeat (5) @(posedge clk);
        #1;
        chk({26'h0, tv}, 32'h3F);
        for (int k = 0; k < NUM_QUEUES; k++) begin
            chk(32'(tr[k]), {17'h0, 6'(k), (k == 5) ? 9'h1FF : 9'h000});
        end
        go <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        chk({26'h0, tv}, 32'h0);
        chk({24'h0, taken}, 32'h8);
        // Set 0 word 0 hits all but the remapped and reserved maps
        qhit({1'b1, 8'h00, 3'h0}, 8'hF5);
        qhit({1'b1, 8'h12, 3'h5}, 8'h08);
        qhit({1'b1, 8'h12, 3'h4}, 8'h00);
        results();
    end
endmodule
bind dcmqr_top dcmqr_chk dcmqr_chk_i (.i_ref_clk, .i_rst, .i_hsel, .i_htrans, .i_hwrite,
    .i_hready, .o_hreadyout, .o_hresp, .i_pset_wr, .o_triggered_write_channel_evt, .o_tr_valid, .o_tr, .i_tr_ready);
`default_nettype wire
